// ### aic_top.sv
// aic_top.sv: fault latching, alarm blink codes, link indicators and switch decode
// assumes motion and link logic share sys_clk; sensors and switches are raw pins
`timescale 1ns/10ps
`include "aic_regs.svh"
module aic_top
	import aic_pkg::*;
#(
	parameter int unsigned BLINK_ON_CYC = `AIC_BLINK_ON_MS * `AIC_CLK_KHZ,
	parameter int unsigned BLINK_OFF_CYC = `AIC_BLINK_OFF_MS * `AIC_CLK_KHZ,
	parameter int unsigned BLINK_GAP_CYC = `AIC_BLINK_GAP_MS * `AIC_CLK_KHZ,
	parameter int unsigned ACT_HOLD_CYC = `AIC_ACT_HOLD_MS * `AIC_CLK_KHZ,
	parameter int unsigned MS_CYC = `AIC_CLK_KHZ,
	parameter int POS_W = 32,
	parameter int DEV_W = 24
) (
	input wire logic sys_clk, // system clock, 25 MHz
	input wire logic arst_n, // async reset, active low
	input wire aic_pin_type pins, // raw sensor and switch pins
	input wire logic [7:0] temp_c, // internal temperature, deg C
	input wire logic encoder_fitted, // encoder variant strap
	input wire logic [DEV_W-1:0] deviation, // |encoder - command|
	input wire logic [DEV_W-1:0] stepout_band, // stepout detection band
	input wire logic signed [POS_W-1:0] cmd_pos, // commanded position
	input wire logic signed [POS_W-1:0] soft_lim_pos, // positive software limit
	input wire logic signed [POS_W-1:0] soft_lim_neg, // negative software limit
	input wire logic soft_lim_en, // software limits enabled
	input wire aic_motion_type motion, // motion status
	input wire aic_link_type link, // link events
	input wire logic [15:0] timeout_ms, // link timeout, 0 disables
	output logic power_led_q, // power lamp
	output logic alarm_led_q, // alarm lamp
	output logic comm_err_led_q, // link error lamp
	output logic comm_activity_led_q, // link activity lamp
	output logic alarm_active_q, // an alarm is latched
	output logic [3:0] alarm_blinks_q, // blinks per burst
	output aic_cfg_type cfg_q, // captured switch settings
	output logic cfg_valid_q, // cfg_q holds captured values
	output logic [19:0] baud_bps_q // decoded baud rate
);

	// ----------------------------------------------------------------
	// pin synchronisation
	// ----------------------------------------------------------------
	aic_pin_type pin_s;

	aic_sync #(.WIDTH($bits(aic_pin_type))) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in(pins),
		.sync_out(pin_s)
	);

	function automatic logic [19:0] baud_of(input logic [2:0] code);
		case (code)
			3'h0: baud_of = `AIC_BAUD_0;
			3'h1: baud_of = `AIC_BAUD_1;
			3'h2: baud_of = `AIC_BAUD_2;
			3'h3: baud_of = `AIC_BAUD_3;
			3'h4: baud_of = `AIC_BAUD_4;
			3'h5: baud_of = `AIC_BAUD_5;
			3'h6: baud_of = `AIC_BAUD_6;
			default: baud_of = `AIC_BAUD_7;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// homing observation
	// ----------------------------------------------------------------
	logic homing_q;
	logic seen_pos_q;
	logic seen_neg_q;
	logic seen_home_q;
	logic seen_index_q;
	logic homing_end;

	assign homing_end = homing_q && !motion.homing_active;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			homing_q <= 1'b0;
			seen_pos_q <= 1'b0;
			seen_neg_q <= 1'b0;
			seen_home_q <= 1'b0;
			seen_index_q <= 1'b0;
		end else begin
			homing_q <= motion.homing_active;
			if (!motion.homing_active) begin
				seen_pos_q <= 1'b0;
				seen_neg_q <= 1'b0;
				seen_home_q <= 1'b0;
				seen_index_q <= 1'b0;
			end else begin
				seen_pos_q <= seen_pos_q | pin_s.pos_limit_sensor;
				seen_neg_q <= seen_neg_q | pin_s.neg_limit_sensor;
				seen_home_q <= seen_home_q | pin_s.mechanical_home_sensor;
				seen_index_q <= seen_index_q | pin_s.slit_sensor | motion.step_timing_output
					| motion.encoder_zero_phase_output;
			end
		end
	end

	// ----------------------------------------------------------------
	// link error count and timeout
	// ----------------------------------------------------------------
	logic [1:0] err_cnt_q;
	logic comm_err_trip;
	logic [31:0] ms_pre_q;
	logic [15:0] ms_cnt_q;
	logic comm_to_trip;

	assign comm_err_trip = link.frame_err && (err_cnt_q == `AIC_COMM_ERR_LAST);
	assign comm_to_trip = (timeout_ms != 16'h0000) && (ms_cnt_q >= timeout_ms);

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_cnt_q <= 2'h0;
		end else if (link.frame_err) begin
			if (err_cnt_q != 2'h3) begin
				err_cnt_q <= err_cnt_q + 2'h1;
			end
		end else if (link.frame_ok) begin
			err_cnt_q <= 2'h0;
		end
	end

	// the host must exchange within timeout_ms; the count restarts on every good frame
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_pre_q <= 32'h0;
			ms_cnt_q <= 16'h0000;
		end else if (link.frame_ok) begin
			ms_pre_q <= 32'h0;
			ms_cnt_q <= 16'h0000;
		end else if (ms_pre_q >= 32'(MS_CYC - 1)) begin
			ms_pre_q <= 32'h0;
			if (ms_cnt_q != 16'hffff) begin
				ms_cnt_q <= ms_cnt_q + 16'h0001;
			end
		end else begin
			ms_pre_q <= ms_pre_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// fault detection and classification
	// ----------------------------------------------------------------
	logic f_overheat;
	logic f_overvolt;
	logic f_overflow;
	logic f_motion;
	logic f_store;
	logic any_fault;
	logic [3:0] blinks_d;
	logic clear_q;
	logic clear_rise;

	always_comb begin
		f_overheat = temp_c > `AIC_TEMP_LIMIT_C;
		f_overvolt = pin_s.overvolt_cmp;
		f_overflow = encoder_fitted && (deviation >= stepout_band);
		f_store = motion.store_corrupt;
		f_motion = (pin_s.pos_limit_sensor && pin_s.neg_limit_sensor)
			|| (motion.homing_active && (motion.homing_dir_pos ?
				pin_s.neg_limit_sensor : pin_s.pos_limit_sensor))
			|| motion.homing_fail
			|| (motion.homing_active && motion.three_sensor_mode && seen_pos_q
				&& seen_neg_q && !seen_home_q)
			|| (homing_end && !seen_index_q)
			|| (!motion.homing_active
				&& (pin_s.pos_limit_sensor || pin_s.neg_limit_sensor))
			|| (soft_lim_en && (cmd_pos >= soft_lim_pos || cmd_pos <= soft_lim_neg))
			|| (motion.homing_active && motion.homing_offset_move
				&& (pin_s.pos_limit_sensor || pin_s.neg_limit_sensor))
			|| motion.data_invalid
			|| comm_err_trip
			|| comm_to_trip;
		any_fault = f_overheat || f_overvolt || f_overflow || f_motion || f_store;
		if (f_overheat) begin
			blinks_d = `AIC_BLINKS_OVERHEAT;
		end else if (f_overvolt) begin
			blinks_d = `AIC_BLINKS_OVERVOLT;
		end else if (f_overflow) begin
			blinks_d = `AIC_BLINKS_OVERFLOW;
		end else if (f_motion) begin
			blinks_d = `AIC_BLINKS_MOTION;
		end else begin
			blinks_d = `AIC_BLINKS_STORE;
		end
	end

	assign clear_rise = pin_s.alarm_clear && !clear_q;

	// first fault wins the code; a fault still present blocks the clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			clear_q <= 1'b0;
			alarm_active_q <= 1'b0;
			alarm_blinks_q <= 4'h0;
		end else begin
			clear_q <= pin_s.alarm_clear;
			if (!alarm_active_q && any_fault) begin
				alarm_active_q <= 1'b1;
				alarm_blinks_q <= blinks_d;
			end else if (alarm_active_q && clear_rise && !any_fault) begin
				alarm_active_q <= 1'b0;
				alarm_blinks_q <= 4'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// alarm lamp blink sequencer
	// ----------------------------------------------------------------
	aic_blink_type st_q;
	aic_blink_type st_d;
	logic [31:0] tmr_q;
	logic [3:0] left_q;
	logic tmr_done;

	assign tmr_done = (tmr_q == 32'h0);

	always_comb begin
		st_d = st_q;
		if (!alarm_active_q) begin
			st_d = AIC_ST_IDLE;
		end else begin
			case (st_q)
				AIC_ST_IDLE: st_d = AIC_ST_ON;
				AIC_ST_ON: if (tmr_done) st_d = AIC_ST_OFF;
				AIC_ST_OFF: if (tmr_done) st_d = (left_q <= 4'h1) ? AIC_ST_GAP : AIC_ST_ON;
				AIC_ST_GAP: if (tmr_done) st_d = AIC_ST_ON;
				default: st_d = AIC_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= AIC_ST_IDLE;
			tmr_q <= 32'h0;
			left_q <= 4'h0;
			alarm_led_q <= 1'b0;
		end else begin
			st_q <= st_d;
			alarm_led_q <= (st_d == AIC_ST_ON);
			if (st_d != st_q) begin
				case (st_d)
					AIC_ST_ON: tmr_q <= 32'(BLINK_ON_CYC - 1);
					AIC_ST_OFF: tmr_q <= 32'(BLINK_OFF_CYC - 1);
					AIC_ST_GAP: tmr_q <= 32'(BLINK_GAP_CYC - 1);
					default: tmr_q <= 32'h0;
				endcase
			end else if (!tmr_done) begin
				tmr_q <= tmr_q - 32'h1;
			end
			if (st_q != AIC_ST_OFF && st_d == AIC_ST_ON && st_q != AIC_ST_ON) begin
				left_q <= alarm_blinks_q;
			end else if (st_q == AIC_ST_OFF && st_d != AIC_ST_OFF) begin
				left_q <= left_q - 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// link lamps
	// ----------------------------------------------------------------
	logic [31:0] act_tmr_q;

	// set wins: an error in the same cycle as a good frame keeps the lamp lit
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			comm_err_led_q <= 1'b0;
		end else if (link.frame_err) begin
			comm_err_led_q <= 1'b1;
		end else if (link.frame_ok) begin
			comm_err_led_q <= 1'b0;
		end
	end

	// stretched so a short frame is still visible
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			act_tmr_q <= 32'h0;
			comm_activity_led_q <= 1'b0;
		end else if (link.frame_ok || link.busy) begin
			act_tmr_q <= 32'(ACT_HOLD_CYC - 1);
			comm_activity_led_q <= 1'b1;
		end else begin
			if (act_tmr_q != 32'h0) begin
				act_tmr_q <= act_tmr_q - 32'h1;
			end
			comm_activity_led_q <= (act_tmr_q != 32'h0);
		end
	end

	// ----------------------------------------------------------------
	// switch capture after reset
	// ----------------------------------------------------------------
	logic [1:0] cap_cnt_q;

	// wait for the synchroniser to fill, then latch once; later switch moves are ignored
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cap_cnt_q <= 2'h0;
			cfg_valid_q <= 1'b0;
			cfg_q <= '{station_addr: `AIC_ADDR_RESET, baud_code: 3'h0, general_master: 1'b0};
			baud_bps_q <= `AIC_BAUD_0;
			power_led_q <= 1'b0;
		end else begin
			power_led_q <= 1'b1;
			if (cap_cnt_q != 2'h3) begin
				cap_cnt_q <= cap_cnt_q + 2'h1;
			end
			if (cap_cnt_q == `AIC_CAPTURE_AT) begin
				cfg_valid_q <= 1'b1;
				cfg_q.station_addr <= pin_s.station_address_switch;
				cfg_q.baud_code <= pin_s.function_switch_bank[2:0];
				cfg_q.general_master <= pin_s.function_switch_bank[3];
				baud_bps_q <= baud_of(pin_s.function_switch_bank[2:0]);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_burst_begin;
		(st_q == AIC_ST_IDLE) && alarm_active_q ##1 (st_q == AIC_ST_ON);
	endsequence

	chk_overheat_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
		f_overheat && !alarm_active_q |=> alarm_active_q && alarm_blinks_q == 4'h2)
		else $error("overheat did not latch a two-blink alarm");
	chk_alarm_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
		alarm_active_q && !clear_rise |=> alarm_active_q && $stable(alarm_blinks_q))
		else $error("latched alarm changed without a clear");
	chk_burst_led: assert property (@(posedge sys_clk) disable iff (!arst_n)
		s_burst_begin |-> alarm_led_q)
		else $error("burst did not start with the lamp lit");
	chk_gap_dark: assert property (@(posedge sys_clk) disable iff (!arst_n)
		st_q == AIC_ST_GAP |-> !alarm_led_q)
		else $error("alarm lamp lit during the burst gap");
	chk_comm_three: assert property (@(posedge sys_clk) disable iff (!arst_n)
		link.frame_err && err_cnt_q == 2'h2 && !alarm_active_q |=> alarm_active_q)
		else $error("third consecutive link error did not alarm");
	chk_comm_first: assert property (@(posedge sys_clk) disable iff (!arst_n)
		link.frame_err && err_cnt_q == 2'h0 && !any_fault && !alarm_active_q
		|=> err_cnt_q == 2'h1 && !alarm_active_q)
		else $error("single link error mishandled");
	chk_err_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
		link.frame_err |=> comm_err_led_q)
		else $error("link error lamp not lit");
	chk_act_lamp: assert property (@(posedge sys_clk) disable iff (!arst_n)
		link.frame_ok |=> comm_activity_led_q [*2])
		else $error("activity lamp not lit after exchange");
	chk_cfg_capture: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cap_cnt_q == 2'h2 |=> cfg_valid_q
		&& cfg_q.station_addr == $past(pin_s.station_address_switch)
		&& cfg_q.general_master == $past(pin_s.function_switch_bank[3]))
		else $error("switches not captured after reset");
	chk_baud_map: assert property (@(posedge sys_clk) disable iff (!arst_n)
		cfg_valid_q |-> baud_bps_q == baud_of(cfg_q.baud_code))
		else $error("baud rate does not match switch code");
	chk_overtravel: assert property (@(posedge sys_clk) disable iff (!arst_n)
		pin_s.pos_limit_sensor && !motion.homing_active && !f_overheat && !f_overvolt
		&& !f_overflow && !alarm_active_q |=> alarm_active_q && alarm_blinks_q == 4'h7)
		else $error("limit sensor did not raise a seven-blink alarm");

endmodule // aic_top

// ### aic_regs.svh
// aic_regs.svh: named constants for the alarm, indicator and link-configuration block
// assumes a single 25 MHz system clock; all timing counts derive from it
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AIC_CLK_KHZ 25000
`define AIC_BLINK_ON_MS 200
`define AIC_BLINK_OFF_MS 200
`define AIC_BLINK_GAP_MS 1200
`define AIC_ACT_HOLD_MS 50

// ----------------------------------------------------------------
// thresholds and codes
// ----------------------------------------------------------------
`define AIC_TEMP_LIMIT_C 8'h55
`define AIC_COMM_ERR_LAST 2'h2
`define AIC_CAPTURE_AT 2'h2
`define AIC_ADDR_RESET 4'h0
`define AIC_BLINKS_OVERHEAT 4'h2
`define AIC_BLINKS_OVERVOLT 4'h3
`define AIC_BLINKS_OVERFLOW 4'h4
`define AIC_BLINKS_MOTION 4'h7
`define AIC_BLINKS_STORE 4'h9

// ----------------------------------------------------------------
// baud rates in bit/s, indexed by function switches 1..3
// ----------------------------------------------------------------
`define AIC_BAUD_0 20'h02580
`define AIC_BAUD_1 20'h04b00
`define AIC_BAUD_2 20'h09600
`define AIC_BAUD_3 20'h0e100
`define AIC_BAUD_4 20'h1c200
`define AIC_BAUD_5 20'h3d090
`define AIC_BAUD_6 20'h4c4b4
`define AIC_BAUD_7 20'h98968

`endif

// ### aic_pkg.sv
// aic_pkg.sv: types shared by the alarm/indicator block
// assumes aic_regs.svh supplies the numeric constants
package aic_pkg;

	// pins arriving from outside the clock domain
	typedef struct packed {
		logic pos_limit_sensor;
		logic neg_limit_sensor;
		logic mechanical_home_sensor;
		logic slit_sensor;
		logic overvolt_cmp;
		logic alarm_clear;
		logic [3:0] station_address_switch;
		logic [3:0] function_switch_bank;
	} aic_pin_type;

	// status from the motion logic, same clock
	typedef struct packed {
		logic homing_active;
		logic homing_dir_pos;
		logic homing_offset_move;
		logic homing_fail;
		logic three_sensor_mode;
		logic step_timing_output;
		logic encoder_zero_phase_output;
		logic data_invalid;
		logic store_corrupt;
	} aic_motion_type;

	// serial link events, one-cycle pulses except busy
	typedef struct packed {
		logic frame_err;
		logic frame_ok;
		logic busy;
	} aic_link_type;

	typedef struct packed {
		logic [3:0] station_addr;
		logic [2:0] baud_code;
		logic general_master;
	} aic_cfg_type;

	// gray code along idle -> on -> off -> gap
	typedef enum logic [1:0] {
		AIC_ST_IDLE = 2'h0,
		AIC_ST_ON = 2'h1,
		AIC_ST_OFF = 2'h3,
		AIC_ST_GAP = 2'h2
	} aic_blink_type;

endpackage

// ### aic_sync.sv
// aic_sync.sv: two-flop synchroniser for a bundle of pin levels
// assumes each bit is an independent slow level; no bus coherence
`timescale 1ns/10ps
module aic_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic [WIDTH-1:0] async_in, // raw pin levels
	output logic [WIDTH-1:0] sync_out // synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // aic_sync

// ### aic_host_model.sv
// aic_host_model.sv: master station stand-in that produces link frame events
// assumes the bench raises req only while no frame is in flight
`timescale 1ns/10ps
module aic_host_model
	import aic_pkg::*;
#(
	parameter int KEEP_CYC = 20
) (
	input wire logic sys_clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic req, // start one frame
	input wire logic req_err, // that frame ends in error
	input wire logic keep_en, // send good frames unprompted
	output aic_link_type link // frame events toward the block
);
	logic [1:0] busy_q;
	logic err_q;
	logic ok_q;
	logic bad_q;
	logic [7:0] keep_q;

	// --------------------
	// frame sequencer
	// --------------------
	// a frame is two busy cycles, then a one-cycle ok or error pulse
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_q <= 2'h0;
			err_q <= 1'b0;
			ok_q <= 1'b0;
			bad_q <= 1'b0;
			keep_q <= 8'h00;
		end else begin
			ok_q <= 1'b0;
			bad_q <= 1'b0;
			keep_q <= keep_q + 8'h01;
			if (busy_q != 2'h0) begin
				busy_q <= busy_q - 2'h1;
				ok_q <= (busy_q == 2'h1) && !err_q;
				bad_q <= (busy_q == 2'h1) && err_q;
			end else if (req || (keep_en && keep_q >= 8'(KEEP_CYC))) begin
				busy_q <= 2'h2;
				err_q <= req && req_err;
				keep_q <= 8'h00;
			end
		end
	end

	assign link = '{frame_err: bad_q, frame_ok: ok_q, busy: busy_q != 2'h0};
endmodule // aic_host_model

// ### tb_aic_top.sv
// tb_aic_top.sv: self-checking bench for fault latch, blink codes, lamps and switch decode
// assumes shortened blink and millisecond counts; link events come from aic_host_model
`timescale 1ns/10ps
module tb_aic_top
	import aic_pkg::*;
;
	localparam int ON_C = 4;
	localparam int OFF_C = 4;
	localparam int GAP_C = 20;
	localparam int HOLD_C = 4;
	typedef struct packed {
		logic [7:0] t;
		logic [10:0] f;
		logic [7:0] d;
		logic ea;
		logic [3:0] eb;
	} aic_row_type;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	aic_pin_type pins = '0;
	aic_motion_type motion = '0;
	logic [7:0] temp_c = 8'h00;
	logic encoder_fitted = 1'b0;
	logic [23:0] deviation = 24'h000000;
	logic [23:0] stepout_band = 24'h000010;
	logic signed [31:0] cmd_pos = 32'h00000000;
	logic signed [31:0] soft_lim_pos = 32'h00000010;
	logic signed [31:0] soft_lim_neg = 32'hfffffff0;
	logic soft_lim_en = 1'b0;
	logic [15:0] timeout_ms = 16'h0000;
	logic req = 1'b0;
	logic req_err = 1'b0;
	logic keep_en = 1'b0;
	aic_link_type link;
	logic power_led_q, alarm_led_q, comm_err_led_q, comm_activity_led_q, alarm_active_q;
	logic [3:0] alarm_blinks_q;
	aic_cfg_type cfg_q;
	logic cfg_valid_q;
	logic [19:0] baud_bps_q;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [19:0] baud_tab [8] = '{20'h02580, 20'h04b00, 20'h09600, 20'h0e100,
		20'h1c200, 20'h3d090, 20'h4c4b4, 20'h98968};
	aic_row_type rows [19];
	aic_row_type rz = '0;

	always #20 sys_clk = ~sys_clk;

	aic_top #(.BLINK_ON_CYC(ON_C), .BLINK_OFF_CYC(OFF_C), .BLINK_GAP_CYC(GAP_C),
		.ACT_HOLD_CYC(HOLD_C), .MS_CYC(10)) aic_top_i (
		.sys_clk(sys_clk), .arst_n(arst_n), .pins(pins), .temp_c(temp_c),
		.encoder_fitted(encoder_fitted), .deviation(deviation), .stepout_band(stepout_band),
		.cmd_pos(cmd_pos), .soft_lim_pos(soft_lim_pos), .soft_lim_neg(soft_lim_neg),
		.soft_lim_en(soft_lim_en), .motion(motion), .link(link), .timeout_ms(timeout_ms),
		.power_led_q(power_led_q), .alarm_led_q(alarm_led_q), .comm_err_led_q(comm_err_led_q),
		.comm_activity_led_q(comm_activity_led_q), .alarm_active_q(alarm_active_q),
		.alarm_blinks_q(alarm_blinks_q), .cfg_q(cfg_q), .cfg_valid_q(cfg_valid_q),
		.baud_bps_q(baud_bps_q));
	aic_host_model aic_host_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .req(req),
		.req_err(req_err), .keep_en(keep_en), .link(link));

	// --------------------
	// helpers
	// --------------------
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// inputs always move one ns after the rising edge
	task automatic step(int n);
		repeat (n) begin
			@(posedge sys_clk);
			#1;
		end
	endtask

	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic done(string s);
		$display("test %s finished", s);
	endtask

	task automatic apply(aic_row_type r);
		motion = '0;
		temp_c = r.t;
		pins.overvolt_cmp = r.f[0];
		encoder_fitted = r.f[1];
		pins.pos_limit_sensor = r.f[2];
		pins.neg_limit_sensor = r.f[3];
		motion.data_invalid = r.f[4];
		motion.store_corrupt = r.f[5];
		soft_lim_en = r.f[6];
		motion.homing_active = r.f[7];
		motion.step_timing_output = r.f[7];
		motion.homing_dir_pos = r.f[8];
		motion.homing_offset_move = r.f[9];
		motion.homing_fail = r.f[10];
		deviation = 24'(r.d);
		cmd_pos = 32'(r.d);
	endtask

	// faults are withdrawn first: a clear while a fault holds is ignored
	task automatic clr();
		apply(rz);
		step(2);
		pins.alarm_clear = 1'b1;
		step(4);
		pins.alarm_clear = 1'b0;
		step(4);
		chk("cleared", 32'(alarm_active_q), 32'h0);
		chk("lamp dark", 32'(alarm_led_q), 32'h0);
	endtask

	// a long dark spell marks a burst edge; count rises between two of them
	task automatic burst(output int n, output int g);
		int off;
		int c;
		int ph;
		n = 0;
		g = 0;
		off = 0;
		c = 0;
		ph = 0;
		while (ph < 2 && c < 600) begin
			step(1);
			c++;
			if (alarm_led_q === 1'b1) begin
				if (off > OFF_C + 2) begin
					ph++;
					g = off;
				end
				if (ph == 1 && off > 0) n++;
				off = 0;
			end else begin
				off++;
			end
		end
	endtask

	task automatic frame(logic e);
		req = 1'b1;
		req_err = e;
		step(1);
		req = 1'b0;
		step(1);
		chk("activity", 32'(comm_activity_led_q), 32'h1);
		step(5);
	endtask

	task automatic do_reset(int n);
		arst_n = 1'b0;
		step(n);
		chk("rst baud", 32'(baud_bps_q), 32'h02580);
		chk("rst alarm", 32'(alarm_active_q), 32'h0);
		arst_n = 1'b1;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			num_errors++;
			print_verdict();
		end
	end

	// --------------------
	// main sequence
	// --------------------
	initial begin
		int n;
		int g;
		rows = '{'{8'h55, 11'h000, 8'h00, 1'b0, 4'h0}, '{8'h56, 11'h000, 8'h00, 1'b1, 4'h2},
			'{8'h00, 11'h001, 8'h00, 1'b1, 4'h3}, '{8'h00, 11'h002, 8'h10, 1'b1, 4'h4},
			'{8'h00, 11'h000, 8'h10, 1'b0, 4'h0}, '{8'h00, 11'h002, 8'h0f, 1'b0, 4'h0},
			'{8'h00, 11'h004, 8'h00, 1'b1, 4'h7}, '{8'h00, 11'h008, 8'h00, 1'b1, 4'h7},
			'{8'h00, 11'h00c, 8'h00, 1'b1, 4'h7}, '{8'h00, 11'h010, 8'h00, 1'b1, 4'h7},
			'{8'h00, 11'h020, 8'h00, 1'b1, 4'h9}, '{8'h00, 11'h040, 8'h10, 1'b1, 4'h7},
			'{8'h00, 11'h040, 8'h0f, 1'b0, 4'h0}, '{8'h00, 11'h188, 8'h00, 1'b1, 4'h7},
			'{8'h00, 11'h084, 8'h00, 1'b1, 4'h7}, '{8'h00, 11'h384, 8'h00, 1'b1, 4'h7},
			'{8'h00, 11'h480, 8'h00, 1'b1, 4'h7}, '{8'h5a, 11'h020, 8'h00, 1'b1, 4'h2},
			'{8'h00, 11'h180, 8'h00, 1'b0, 4'h0}};
		for (int k = 0; k < 8; k++) begin
			pins.function_switch_bank = {k[1], k[2:0]};
			pins.station_address_switch = 4'(k * 5);
			do_reset(k == 0 ? 20 : 2);
			step(5);
			chk("power", 32'(power_led_q), 32'h1);
			chk("cfg valid", 32'(cfg_valid_q), 32'h1);
			chk("addr", 32'(cfg_q.station_addr), 32'((k * 5) % 16));
			chk("code", 32'(cfg_q.baud_code), 32'(k));
			chk("general", 32'(cfg_q.general_master), 32'(k[1]));
			chk("baud", 32'(baud_bps_q), 32'(baud_tab[k]));
		end
		done("switch decode");
		pins.function_switch_bank = 4'h0;
		pins.station_address_switch = 4'hf;
		step(6);
		chk("addr held", 32'(cfg_q.station_addr), 32'h3);
		chk("baud held", 32'(baud_bps_q), 32'h98968);
		done("switch hold");
		foreach (rows[i]) begin
			apply(rows[i]);
			step(8);
			chk("active", 32'(alarm_active_q), 32'(rows[i].ea));
			if (rows[i].ea) begin
				chk("blinks", 32'(alarm_blinks_q), 32'(rows[i].eb));
				burst(n, g);
				chk("burst", 32'(n), 32'(rows[i].eb));
				chk("gap", 32'(g >= GAP_C && g <= GAP_C + OFF_C + 1), 32'h1);
				apply(rz);
				step(4);
				chk("latched", 32'(alarm_active_q), 32'h1);
			end
			clr();
		end
		done("fault rows");
		for (int k = 0; k < 4; k++) begin
			motion.homing_active = 1'b1;
			step(4);
			pins.slit_sensor = (k == 0);
			motion.step_timing_output = (k == 1);
			motion.encoder_zero_phase_output = (k == 2);
			step(6);
			pins.slit_sensor = 1'b0;
			apply(rz);
			step(6);
			chk("homing seen", 32'(alarm_active_q), 32'(k == 3));
			clr();
		end
		done("homing indicators");
		// limits are met one at a time, each on the leading side, so only the home check can trip
		for (int k = 0; k < 2; k++) begin
			motion.homing_active = 1'b1;
			motion.three_sensor_mode = 1'b1;
			motion.step_timing_output = 1'b1;
			motion.homing_dir_pos = 1'b1;
			pins.pos_limit_sensor = 1'b1;
			step(4);
			pins.pos_limit_sensor = 1'b0;
			pins.mechanical_home_sensor = (k == 0);
			step(4);
			pins.mechanical_home_sensor = 1'b0;
			motion.homing_dir_pos = 1'b0;
			pins.neg_limit_sensor = 1'b1;
			step(5);
			chk("no home", 32'(alarm_active_q), 32'(k == 1));
			pins.neg_limit_sensor = 1'b0;
			step(4);
			clr();
		end
		done("three-sensor homing");
		frame(1'b1);
		frame(1'b1);
		chk("err lamp", 32'(comm_err_led_q), 32'h1);
		frame(1'b0);
		chk("err lamp off", 32'(comm_err_led_q), 32'h0);
		frame(1'b1);
		frame(1'b1);
		chk("link alarm", 32'(alarm_active_q), 32'h0);
		frame(1'b1);
		chk("link alarm", 32'(alarm_active_q), 32'h1);
		chk("link blinks", 32'(alarm_blinks_q), 32'h7);
		frame(1'b0);
		step(HOLD_C + 4);
		chk("activity off", 32'(comm_activity_led_q), 32'h0);
		clr();
		done("link errors");
		keep_en = 1'b1;
		step(30);
		timeout_ms = 16'h0005;
		step(150);
		chk("fed link", 32'(alarm_active_q), 32'h0);
		keep_en = 1'b0;
		step(80);
		chk("timeout", 32'(alarm_active_q), 32'h1);
		chk("timeout blinks", 32'(alarm_blinks_q), 32'h7);
		timeout_ms = 16'h0000;
		clr();
		done("link timeout");
		print_verdict();
	end
endmodule // tb_aic_top
